//--- inc/sysbus_slice_pkg.sv
// shared constants, command codes and check-bit helpers for the data slice
package sysbus_slice_pkg;

   localparam int DATA_W   = 64;
   localparam int LWORD_W  = 32;
   localparam int LINES    = 4;
   localparam int SUBLINES = 4;

   // system command codes, sampled with the sub-command at phase two fall
   typedef enum logic [2:0] {
      CMD_CONTROL                 = 3'b000,
      CMD_PAD_LOAD                = 3'b001,
      DMA_READ_LOAD_FROM_PADS     = 3'b010,
      DMA_READ_LOAD_FROM_MEMORY   = 3'b011,
      CMD_MERGE                   = 3'b100,
      LINE_WRITE_FROM_PADS        = 3'b101,
      DMA_MERGE_WRITE_FROM_PADS   = 3'b110,
      DMA_MERGE_WRITE_FROM_MEMORY = 3'b111
   } sys_cmd_t;

   // sub-command bit 1 picks hold over reset under the control command
   localparam int          SUB_HOLD_BIT = 1;
   localparam logic [1:0]  SUB_RESET    = 2'b00;
   localparam logic [1:0]  SUB_HOLD     = 2'b10;

   // four controller phases per system cycle
   typedef enum logic [1:0] {
      PH_ONE_RISE = 2'b00,
      PH_ONE_FALL = 2'b01,
      PH_TWO_RISE = 2'b10,
      PH_TWO_FALL = 2'b11
   } phase_t;

   // check field positions
   localparam int SYS_ECC_LO  = 32;
   localparam int MEM_ECC_LO  = 57;
   localparam int CSR_LANE_HI = 15;

   // ecc column masks (single-error-correct style coverage)
   localparam logic [6:0][31:0] ECC_MASK = {
      32'hfe00_0000, 32'h01ff_8000, 32'h8078_7f80,
      32'h4c66_6c78, 32'h2a55_5ab6, 32'h1933_b56d, 32'hd4aa_ab5b
   };

   function automatic logic [6:0] ecc32(input logic [31:0] d);
      logic [6:0] e;
      e = 7'h00;
      for (int i = 0; i < 7; i++) begin
         e[i] = ^(d & ECC_MASK[i]);
      end
      return e;
   endfunction

   // byte merge: dma byte wins where its valid bit is set
   function automatic logic [63:0] byte_merge(input logic [63:0] base,
                                              input logic [63:0] dma,
                                              input logic [7:0]  valid);
      logic [63:0] r;
      r = base;
      for (int b = 0; b < 8; b++) begin
         if (valid[b]) begin
            r[b*8 +: 8] = dma[b*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

//--- inc/sysbus_link_if.sv
// link between the data slice and its cache/memory controller
`timescale 1ns/1ns
interface sysbus_link_if;
   logic        phase_one_rise;
   logic        phase_one_fall;
   logic        phase_two_fall;
   logic [2:0]  system_command;
   logic [1:0]  system_subcommand;
   logic        system_drive_strobe;
   logic        csr_hold_strobe;
   logic        memory_drive_strobe;
   logic        io_read_select;
   logic        upper_octaword_select;
   logic        overlay_inverted_merge;
   // slice drivers on the cpu-side bus
   logic [63:0] dp_data_out;
   logic        dp_hi_oe;
   logic        dp_lo_oe;
   logic [1:0]  dp_par_out;
   logic        dp_par_oe;
   // processor default drive, supplied by the bench
   logic [63:0] cpu_data_drive;
   logic [1:0]  cpu_par_drive;
   // memory-side drivers
   logic [31:0] mem_data_out;
   logic        mem_par_out;
   logic        mem_oe;
   // resolved wire levels
   logic [63:0] cpu_side_data_bus;
   logic [1:0]  cpu_side_parity_bits;

   assign cpu_side_data_bus[63:16] = dp_hi_oe ? dp_data_out[63:16]
                                              : cpu_data_drive[63:16];
   assign cpu_side_data_bus[15:0]  = dp_lo_oe ? dp_data_out[15:0]
                                              : cpu_data_drive[15:0];
   assign cpu_side_parity_bits     = dp_par_oe ? dp_par_out : cpu_par_drive;

   modport datapath (
      input  phase_one_rise, phase_one_fall, phase_two_fall,
      input  system_command, system_subcommand, system_drive_strobe,
      input  csr_hold_strobe, memory_drive_strobe, io_read_select,
      input  upper_octaword_select, overlay_inverted_merge,
      input  cpu_side_data_bus, cpu_side_parity_bits,
      output dp_data_out, dp_hi_oe, dp_lo_oe, dp_par_out, dp_par_oe,
      output mem_data_out, mem_par_out, mem_oe
   );
   modport controller (
      output phase_one_rise, phase_one_fall, phase_two_fall,
      output system_command, system_subcommand, system_drive_strobe,
      output csr_hold_strobe, memory_drive_strobe, io_read_select,
      output upper_octaword_select, overlay_inverted_merge
   );
endinterface

//--- rtl/sysbus_controller_end.sv
// controller end: phase generator and command issue toward the data slice
`timescale 1ns/1ns
module sysbus_controller_end (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   sysbus_link_if.controller link,
   input  wire logic       req_valid,
   output logic            req_ready,
   input  wire logic [2:0] req_command,
   input  wire logic [1:0] req_subcommand,
   input  wire logic       req_drive,
   input  wire logic       req_csr_hold,
   input  wire logic       req_io_read,
   input  wire logic       req_upper,
   input  wire logic       req_overlay,
   input  wire logic       mem_drive
);

   typedef struct packed {
      sysbus_slice_pkg::phase_t phase;
      logic       pend;
      logic [2:0] p_cmd;
      logic [1:0] p_sub;
      logic [4:0] p_ctl;   // drive, csr, io, upper, overlay
      logic [2:0] cmd;
      logic [1:0] sub;
      logic [4:0] ctl;
      logic       mem_drv;
   } ctrl_state_t;

   ctrl_state_t st_q;
   ctrl_state_t st_d;

   ////////////////////////////////////////////////////////////////////////
   // one request slot; a new one is refused until the slot empties
   assign req_ready = ~st_q.pend;

   always_comb begin
      st_d         = st_q;
      st_d.phase   = sysbus_slice_pkg::phase_t'(st_q.phase + 2'b01);
      st_d.mem_drv = mem_drive;
      if (req_valid && !st_q.pend) begin
         st_d.pend  = 1'b1;
         st_d.p_cmd = req_command;
         st_d.p_sub = req_subcommand;
         st_d.p_ctl = {req_drive, req_csr_hold, req_io_read,
                       req_upper, req_overlay};
      end
      // a new system cycle opens: issue pending work, else a hold
      if (st_q.phase == sysbus_slice_pkg::PH_TWO_FALL) begin
         if (st_q.pend) begin
            st_d.cmd  = st_q.p_cmd;
            st_d.sub  = st_q.p_sub;
            st_d.ctl  = st_q.p_ctl;
            st_d.pend = 1'b0;
         end else begin
            st_d.cmd = sysbus_slice_pkg::CMD_CONTROL;
            st_d.sub = sysbus_slice_pkg::SUB_HOLD;
            st_d.ctl = 5'h00;
         end
      end
   end

   // hold state defaults to a quiet link issuing the hold command
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q     <= '0;
         st_q.sub <= sysbus_slice_pkg::SUB_HOLD;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // phase strobes decode straight from the phase register
   assign link.phase_one_rise = st_q.phase == sysbus_slice_pkg::PH_ONE_RISE;
   assign link.phase_one_fall = st_q.phase == sysbus_slice_pkg::PH_ONE_FALL;
   assign link.phase_two_fall = st_q.phase == sysbus_slice_pkg::PH_TWO_FALL;
   assign link.system_command         = st_q.cmd;
   assign link.system_subcommand      = st_q.sub;
   assign link.system_drive_strobe    = st_q.ctl[4];
   assign link.csr_hold_strobe        = st_q.ctl[3];
   assign link.io_read_select         = st_q.ctl[2];
   assign link.upper_octaword_select  = st_q.ctl[1];
   assign link.overlay_inverted_merge = st_q.ctl[0];
   assign link.memory_drive_strobe    = st_q.mem_drv;

endmodule

//--- rtl/sysbus_datapath_end.sv
// cpu-side data path slice: pad latches, buffers and bus drivers
`timescale 1ns/1ns
module sysbus_datapath_end (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   sysbus_link_if.datapath  link,
   input  wire logic        ecc_strap,
   input  wire logic        mem_rd_we,
   input  wire logic [1:0]  mem_rd_idx,
   input  wire logic [63:0] mem_rd_data,
   input  wire logic        io_rd_we,
   input  wire logic [1:0]  io_rd_idx,
   input  wire logic [63:0] io_rd_data,
   input  wire logic [63:0] dma_wr_data,
   input  wire logic [7:0]  dma_wr_valid,
   input  wire logic [1:0]  dma_rd_idx,
   output logic [63:0]      dma_rd_data,
   input  wire logic [1:0]  mem_line_sel,
   input  wire logic [1:0]  mem_sub_sel,
   input  wire logic        mem_half_sel,
   output logic [7:0]       merge_bits
);

   typedef struct packed {
      logic [1:0]             strap_sync;
      logic [63:0]            pad_data;
      logic                   drv_hi;
      logic                   drv_lo;
      logic [63:0]            out_data;
      logic [1:0]             out_par;
      logic                   upper;
      logic                   io_sel;
      logic                   rd_half;
      logic [3:0][1:0]        merge_set;
      logic [1:0]             merge_cnt;
      logic [3:0][63:0]       dma_rd_buf;
      logic [1:0]             dma_cnt;
      logic [3:0][3:0][63:0]  wr_buf;
      logic [3:0][1:0]        wr_cnt;
      logic [3:0][63:0]       mem_rd_buf;
      logic [3:0][63:0]       io_rd_buf;
      logic [31:0]            mem_out;
      logic [63:0]            dma_out;
   } dp_state_t;

   dp_state_t   st_q;
   dp_state_t   st_d;
   logic [1:0]  rd_idx;
   logic [63:0] src_word;
   logic [63:0] ecc_word;
   logic [6:0]  mem_ecc;
   logic [63:0] merged;
   logic [1:0]  line;

   ////////////////////////////////////////////////////////////////////////
   // read source and check-bit placement for the next launch
   assign rd_idx  = {st_q.upper, st_q.rd_half};
   assign line    = link.system_subcommand;
   assign mem_ecc = sysbus_slice_pkg::ecc32(st_q.mem_rd_buf[rd_idx][31:0]);

   always_comb begin
      src_word = st_q.io_sel ? st_q.io_rd_buf[rd_idx]
                             : st_q.mem_rd_buf[rd_idx];
      ecc_word = src_word;
      ecc_word[sysbus_slice_pkg::SYS_ECC_LO +: 7] =
         sysbus_slice_pkg::ecc32(src_word[31:0]);
      // memory check bits land in reversed order, bit 63 carries bit 0
      for (int i = 0; i < 7; i++) begin
         ecc_word[63 - i] = mem_ecc[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command engine, bus launch and user-side buffer ports
   always_comb begin
      st_d            = st_q;
      st_d.strap_sync = {st_q.strap_sync[0], ecc_strap};
      merged          = 64'h0;
      // launch on phase-one rise; strobe seen now drives from the next edge
      if (link.phase_one_rise) begin
         st_d.drv_hi = link.system_drive_strobe;
         st_d.drv_lo = link.system_drive_strobe &&
                       !link.csr_hold_strobe;
         if (st_q.strap_sync[1]) begin
            st_d.out_data = ecc_word;
            st_d.out_par  = 2'b00;
         end else begin
            st_d.out_data = src_word;
            st_d.out_par  = {^src_word[63:32], ^src_word[31:0]};
         end
         if (link.system_drive_strobe) begin
            st_d.rd_half = ~st_q.rd_half;
         end
      end
      // drivers release at phase-one fall, handing the bus back
      if (link.phase_one_fall) begin
         st_d.drv_hi = 1'b0;
         st_d.drv_lo = 1'b0;
      end
      // commands act on the pad data held from the prior cycle
      if (link.phase_two_fall) begin
         st_d.upper  = link.upper_octaword_select;
         st_d.io_sel = link.io_read_select;
         if (link.system_command != sysbus_slice_pkg::CMD_CONTROL) begin
            st_d.pad_data = link.cpu_side_data_bus;
         end
         case (sysbus_slice_pkg::sys_cmd_t'(link.system_command))
            sysbus_slice_pkg::CMD_CONTROL: begin
               if (!link.system_subcommand[sysbus_slice_pkg::SUB_HOLD_BIT])
               begin
                  st_d.merge_set = '0;
                  st_d.merge_cnt = 2'b00;
                  st_d.dma_cnt   = 2'b00;
                  st_d.wr_cnt    = '0;
                  st_d.rd_half   = 1'b0;
               end
            end
            sysbus_slice_pkg::CMD_PAD_LOAD: begin
            end
            sysbus_slice_pkg::DMA_READ_LOAD_FROM_PADS: begin
               st_d.dma_rd_buf[st_q.dma_cnt] = st_q.pad_data;
               st_d.dma_cnt = st_q.dma_cnt + 2'b01;
            end
            sysbus_slice_pkg::DMA_READ_LOAD_FROM_MEMORY: begin
               st_d.dma_rd_buf[st_q.dma_cnt] =
                  st_q.mem_rd_buf[st_q.dma_cnt];
               st_d.dma_cnt = st_q.dma_cnt + 2'b01;
            end
            sysbus_slice_pkg::CMD_MERGE: begin
               for (int lw = 0; lw < 2; lw++) begin
                  if (link.overlay_inverted_merge) begin
                     if (!st_q.merge_set[st_q.merge_cnt][lw]) begin
                        st_d.mem_rd_buf[st_q.merge_cnt][lw*32 +: 32] =
                           st_q.pad_data[lw*32 +: 32];
                     end
                  end else if (link.system_subcommand[lw]) begin
                     st_d.mem_rd_buf[st_q.merge_cnt][lw*32 +: 32] =
                        st_q.pad_data[lw*32 +: 32];
                     st_d.merge_set[st_q.merge_cnt][lw] = 1'b1;
                  end
               end
               st_d.merge_cnt = st_q.merge_cnt + 2'b01;
            end
            sysbus_slice_pkg::LINE_WRITE_FROM_PADS: begin
               st_d.wr_buf[line][st_q.wr_cnt[line]] = st_q.pad_data;
               st_d.wr_cnt[line] = st_q.wr_cnt[line] + 2'b01;
            end
            sysbus_slice_pkg::DMA_MERGE_WRITE_FROM_PADS: begin
               merged = sysbus_slice_pkg::byte_merge(st_q.pad_data,
                           dma_wr_data, dma_wr_valid);
               st_d.wr_buf[line][st_q.wr_cnt[line]] = merged;
               st_d.wr_cnt[line] = st_q.wr_cnt[line] + 2'b01;
            end
            default: begin
               merged = sysbus_slice_pkg::byte_merge(
                           st_q.mem_rd_buf[st_q.wr_cnt[line]],
                           dma_wr_data, dma_wr_valid);
               st_d.wr_buf[line][st_q.wr_cnt[line]] = merged;
               st_d.wr_cnt[line] = st_q.wr_cnt[line] + 2'b01;
            end
         endcase
      end
      // read and merge share one buffer; a same-edge memory load wins
      if (mem_rd_we) begin
         st_d.mem_rd_buf[mem_rd_idx] = mem_rd_data;
      end
      if (io_rd_we) begin
         st_d.io_rd_buf[io_rd_idx] = io_rd_data;
      end
      st_d.mem_out = mem_half_sel
                   ? st_q.wr_buf[mem_line_sel][mem_sub_sel][63:32]
                   : st_q.wr_buf[mem_line_sel][mem_sub_sel][31:0];
      st_d.dma_out = st_q.dma_rd_buf[dma_rd_idx];
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // drivers; the memory enable is a flow-through of its strobe
   assign link.dp_data_out  = st_q.out_data;
   assign link.dp_hi_oe     = st_q.drv_hi;
   assign link.dp_lo_oe     = st_q.drv_lo;
   assign link.dp_par_out   = st_q.out_par;
   assign link.dp_par_oe    = st_q.drv_hi && !st_q.strap_sync[1];
   assign link.mem_data_out = st_q.mem_out;
   assign link.mem_par_out  = ^st_q.mem_out;
   assign link.mem_oe       = link.memory_drive_strobe;
   assign dma_rd_data       = st_q.dma_out;
   assign merge_bits        = st_q.merge_set;

endmodule

//--- verification/sysbus_slice_assertions.sv
// concurrent checks on the link between controller end and data slice
`timescale 1ns/1ns
module sysbus_slice_assertions (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        phase_one_rise,
   input wire logic        phase_one_fall,
   input wire logic        phase_two_fall,
   input wire logic [2:0]  system_command,
   input wire logic        system_drive_strobe,
   input wire logic        csr_hold_strobe,
   input wire logic        memory_drive_strobe,
   input wire logic [63:0] dp_data_out,
   input wire logic        dp_hi_oe,
   input wire logic        dp_lo_oe,
   input wire logic [1:0]  dp_par_out,
   input wire logic        dp_par_oe,
   input wire logic        mem_oe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////
   // rest of a system cycle after the launch phase
   sequence phase_tail;
      phase_one_fall ##1 !phase_one_fall ##1 phase_two_fall;
   endsequence
   // a launch holds the bus for one clock only, so the cpu regains it
   sequence one_clock_drive;
      dp_hi_oe ##1 !dp_hi_oe;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_phase_cycle: assert property (
      phase_one_rise |=> phase_tail ##1 phase_one_rise
   ) else $error("phase walk broken");
   a_cmd_steady: assert property (
      phase_one_rise |=> $stable(system_command)[*3]
   ) else $error("command moved inside a system cycle");
   a_drive_launch: assert property (
      phase_one_rise && system_drive_strobe |=> one_clock_drive
   ) else $error("upper drive not launched for one clock");
   a_no_drive: assert property (
      phase_one_rise && !system_drive_strobe |=> !dp_hi_oe
   ) else $error("bus driven without drive strobe");
   a_lo_held: assert property (
      phase_one_rise && csr_hold_strobe |=> !dp_lo_oe
   ) else $error("low lane driven under hold");
   a_lo_driven: assert property (
      phase_one_rise && system_drive_strobe && !csr_hold_strobe |=> dp_lo_oe
   ) else $error("low lane not driven");
   a_oe_window: assert property (
      $rose(dp_hi_oe) |-> $past(phase_one_rise)
   ) else $error("drive launched off phase one rise");
   a_lo_needs_hi: assert property (dp_lo_oe |-> dp_hi_oe)
      else $error("low lane driven alone");
   a_par_even: assert property (
      dp_par_oe |-> dp_par_out == {^dp_data_out[63:32], ^dp_data_out[31:0]}
   ) else $error("parity not even per longword");
   a_mem_flow: assert property (mem_oe == memory_drive_strobe)
      else $error("memory drivers not following strobe");
endmodule

//--- verification/tb_top.sv
// bench: controller end steers the data slice end over the shared link
`timescale 1ns/1ns
module tb_top;
   localparam logic [4:0] DRV = 5'h10;
   localparam logic [4:0] CSR = 5'h08;
   localparam logic [4:0] IO  = 5'h04;
   localparam logic [4:0] UP  = 5'h02;
   localparam logic [4:0] OVL = 5'h01;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_ready;
   logic [2:0]  req_command = 3'h0;
   logic [1:0]  req_subcommand = 2'h0;
   logic [4:0]  req_flags = 5'h00;
   logic        mem_drive = 1'b0;
   logic        ecc_strap = 1'b0;
   logic        mem_rd_we = 1'b0;
   logic        io_rd_we = 1'b0;
   logic [1:0]  buf_idx = 2'h0;
   logic [63:0] buf_data = 64'h0;
   logic [63:0] dma_wr_data = 64'h0123_4567_89ab_cdef;
   logic [7:0]  dma_wr_valid = 8'ha5;
   logic [1:0]  dma_rd_idx = 2'h0;
   logic [63:0] dma_rd_data;
   logic [1:0]  mem_line_sel = 2'h0;
   logic [1:0]  mem_sub_sel = 2'h0;
   logic        mem_half_sel = 1'b0;
   logic [7:0]  merge_bits;
   logic [63:0] seen;
   logic [1:0]  seen_par;
   logic [6:0]  rev;
   int          n_errors = 0;
   int          checked = 0;

   sysbus_link_if link ();
   sysbus_controller_end u_sysbus_controller_end (
      .clock(clock), .sys_rst(sys_rst), .link(link),
      .req_valid(req_valid), .req_ready(req_ready),
      .req_command(req_command), .req_subcommand(req_subcommand),
      .req_drive(req_flags[4]), .req_csr_hold(req_flags[3]),
      .req_io_read(req_flags[2]), .req_upper(req_flags[1]),
      .req_overlay(req_flags[0]), .mem_drive(mem_drive)
   );
   sysbus_datapath_end u_sysbus_datapath_end (
      .clock(clock), .sys_rst(sys_rst), .link(link), .ecc_strap(ecc_strap),
      .mem_rd_we(mem_rd_we), .mem_rd_idx(buf_idx), .mem_rd_data(buf_data),
      .io_rd_we(io_rd_we), .io_rd_idx(buf_idx), .io_rd_data(buf_data),
      .dma_wr_data(dma_wr_data), .dma_wr_valid(dma_wr_valid),
      .dma_rd_idx(dma_rd_idx), .dma_rd_data(dma_rd_data),
      .mem_line_sel(mem_line_sel), .mem_sub_sel(mem_sub_sel),
      .mem_half_sel(mem_half_sel), .merge_bits(merge_bits)
   );
   sysbus_slice_assertions u_sysbus_slice_assertions (
      .clock(clock), .sys_rst(sys_rst),
      .phase_one_rise(link.phase_one_rise),
      .phase_one_fall(link.phase_one_fall),
      .phase_two_fall(link.phase_two_fall),
      .system_command(link.system_command),
      .system_drive_strobe(link.system_drive_strobe),
      .csr_hold_strobe(link.csr_hold_strobe),
      .memory_drive_strobe(link.memory_drive_strobe),
      .dp_data_out(link.dp_data_out), .dp_hi_oe(link.dp_hi_oe),
      .dp_lo_oe(link.dp_lo_oe), .dp_par_out(link.dp_par_out),
      .dp_par_oe(link.dp_par_oe), .mem_oe(link.mem_oe)
   );

   // 25 mhz system clock
   always #20 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////
   // distinct bus words, so a wrong buffer slot never matches by chance
   function automatic logic [63:0] pat(input int k);
      return 64'h9e37_79b9_7f4a_7c15 * 64'(k + 1);
   endfunction
   function automatic logic [1:0] par2(input logic [63:0] d);
      return {^d[63:32], ^d[31:0]};
   endfunction
   // dma byte wins where its valid bit is set
   function automatic logic [63:0] mrg(input logic [63:0] b);
      for (int k = 0; k < 8; k++) begin
         if (dma_wr_valid[k]) begin
            b[k*8 +: 8] = dma_wr_data[k*8 +: 8];
         end
      end
      return b;
   endfunction
   function automatic logic [6:0] ecc_ref(input logic [63:0] d);
      logic [6:0] e;
      for (int k = 0; k < 7; k++) begin
         e[k] = ^(d[31:0] & sysbus_slice_pkg::ECC_MASK[k]);
      end
      return e;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      if (n_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait step; a hang ends the run as a failure
   task automatic tick(inout int n);
      @(negedge clock);
      n++;
      if (n > 60) begin
         n_errors++;
         stop_test();
      end
   endtask
   // one command per system cycle; samples the bus one clock after launch,
   // then leaves word k on the cpu side for this command's capture
   task automatic cyc(input logic [2:0] c, input logic [1:0] s,
                      input logic [4:0] f, input int k);
      int n;
      n = 0;
      while (req_ready !== 1'b1) tick(n);
      req_valid = 1'b1;
      req_command = c;
      req_subcommand = s;
      req_flags = f;
      @(negedge clock);
      req_valid = 1'b0;
      while (!(req_ready === 1'b1 && link.phase_one_rise === 1'b1)) tick(n);
      @(negedge clock);
      seen = link.cpu_side_data_bus;
      seen_par = link.cpu_side_parity_bits;
      link.cpu_data_drive = pat(k);
   endtask
   task automatic load_bufs;
      for (int k = 0; k < 4; k++) begin
         buf_idx = k[1:0];
         buf_data = pat(10 + k);
         mem_rd_we = 1'b1;
         @(negedge clock);
         mem_rd_we = 1'b0;
         io_rd_we = 1'b1;
         buf_data = pat(30 + k);
         @(negedge clock);
         io_rd_we = 1'b0;
      end
   endtask
   task automatic rdmem(input logic [1:0] l, input logic [1:0] s,
                        input logic [63:0] e);
      mem_line_sel = l;
      mem_sub_sel = s;
      mem_half_sel = 1'b0;
      @(negedge clock);
      chk(link.mem_data_out, e[31:0]);
      chk(link.mem_par_out, ^e[31:0]);
      mem_half_sel = 1'b1;
      @(negedge clock);
      chk(link.mem_data_out, e[63:32]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence: pads pipeline one command behind the capture
   initial begin
      link.cpu_data_drive = 64'h0;
      link.cpu_par_drive = 2'b01;
      repeat (6) @(negedge clock);
      sys_rst = 1'b0;
      load_bufs();
      mem_drive = 1'b1;
      @(negedge clock);
      chk(link.mem_oe, 1'b1);
      mem_drive = 1'b0;
      @(negedge clock);
      chk(link.mem_oe, 1'b0);
      cyc(3'h0, 2'h0, 5'h00, 1);
      cyc(3'h1, 2'h0, 5'h00, 2);
      cyc(3'h2, 2'h0, 5'h00, 3);
      cyc(3'h3, 2'h0, 5'h00, 4);
      cyc(3'h4, 2'h1, 5'h00, 5);
      cyc(3'h4, 2'h0, 5'h00, 6);
      cyc(3'h4, 2'h3, OVL, 7);
      cyc(3'h4, 2'h2, 5'h00, 8);
      cyc(3'h4, 2'h2, 5'h00, 9);
      cyc(3'h4, 2'h3, 5'h00, 10);
      cyc(3'h5, 2'h2, 5'h00, 11);
      chk(merge_bits, 8'h8f);
      cyc(3'h0, 2'h2, 5'h00, 12);
      cyc(3'h5, 2'h2, 5'h00, 13);
      cyc(3'h5, 2'h0, 5'h00, 14);
      cyc(3'h5, 2'h1, 5'h00, 15);
      cyc(3'h5, 2'h3, 5'h00, 16);
      cyc(3'h6, 2'h3, 5'h00, 17);
      cyc(3'h7, 2'h1, 5'h00, 18);
      // merged sub-lines 0 and 3 read back before the buffer is restored
      cyc(3'h0, 2'h2, DRV | UP, 40);
      chk(seen, (pat(8) & ~64'hffff_ffff) | (pat(4) & 64'hffff_ffff));
      cyc(3'h0, 2'h2, DRV, 41);
      chk(seen, (pat(7) & ~64'hffff_ffff) | (pat(13) & 64'hffff_ffff));
      // merges overwrote the shared read/merge buffer; restore it
      load_bufs();
      cyc(3'h0, 2'h0, 5'h00, 19);
      cyc(3'h0, 2'h2, DRV | UP, 20);
      chk(seen, pat(10));
      chk(seen_par, par2(pat(10)));
      chk(merge_bits, 8'h00);
      cyc(3'h0, 2'h2, DRV | CSR | UP | IO, 21);
      chk(seen, (pat(13) & ~64'hffff) | (pat(20) & 64'hffff));
      cyc(3'h0, 2'h2, DRV | IO, 22);
      chk(seen, pat(32));
      cyc(3'h0, 2'h2, 5'h00, 23);
      chk(seen, pat(22));
      cyc(3'h0, 2'h2, DRV, 24);
      chk(seen, pat(11));
      ecc_strap = 1'b1;
      cyc(3'h0, 2'h0, 5'h00, 25);
      cyc(3'h0, 2'h2, DRV, 26);
      rev = {<<{seen[63:57]}};
      chk(seen[38:32], ecc_ref(pat(10)));
      chk(rev, ecc_ref(pat(10)));
      chk(seen_par, 2'b01);
      rdmem(2'h2, 2'h0, pat(10));
      rdmem(2'h2, 2'h1, pat(11));
      rdmem(2'h0, 2'h0, pat(13));
      rdmem(2'h1, 2'h0, pat(14));
      rdmem(2'h3, 2'h0, pat(15));
      rdmem(2'h3, 2'h1, mrg(pat(16)));
      rdmem(2'h1, 2'h1, mrg(pat(9)));
      dma_rd_idx = 2'h0;
      @(negedge clock);
      chk(dma_rd_data, pat(2));
      dma_rd_idx = 2'h1;
      @(negedge clock);
      chk(dma_rd_data, pat(11));
      stop_test();
   end
endmodule
